// >>> inc/rcs_pkg.sv
/*
 Shared constants and types of the reset and clock sequencer.
 Assumes a single 40 MHz pclk domain.
*/
package rcs_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_MHZ = 40;
   localparam int CLK_HZ = CLK_MHZ * 1000000;
   localparam int MIN_RESET_INPUT_PULSE_NS = 50;
   localparam int MIN_RESET_OUTPUT_PULSE_NS = 500;
   localparam logic [2:0] IN_PULSE_CYC = 3'((MIN_RESET_INPUT_PULSE_NS * CLK_MHZ + 999) / 1000);
   localparam logic [5:0] OUT_PULSE_CYC = 6'((MIN_RESET_OUTPUT_PULSE_NS * CLK_MHZ + 999) / 1000);
   localparam int PLL_IN_MIN_HZ = 2000000;
   localparam int PLL_IN_MAX_HZ = 4000000;
   localparam logic [4:0] PLL_PER_MIN = 5'(CLK_HZ / PLL_IN_MAX_HZ);
   localparam logic [4:0] PLL_PER_MAX = 5'(CLK_HZ / PLL_IN_MIN_HZ);
   localparam logic [4:0] PER_SAT = 5'h1F;
   localparam int DELAY_SHORT_CYC = 256;
   localparam int DELAY_LONG_CYC = 4096;
   localparam logic [12:0] DLY_SHORT_LAST = 13'(DELAY_SHORT_CYC - 1);
   localparam logic [12:0] DLY_LONG_LAST = 13'(DELAY_LONG_CYC - 1);
   localparam logic [15:0] VEC_HI_ADDR = 16'hFFFE;
   localparam logic [15:0] VEC_LO_ADDR = 16'hFFFF;
   // ==========================================================
   // Option fields
   localparam int OPT_SRC_LSB = 0;
   localparam int OPT_RANGE_LSB = 2;
   localparam int OPT_PLL_BIT = 5;
   localparam int OPT_LONG_BIT = 6;
   localparam logic [7:0] OPT_RESET = 8'h40;
   localparam logic [7:0] OPT_MASK = 8'h7F;
   localparam logic [2:0] RANGE_MAX = 3'h4;
   // ==========================================================
   // Register map
   localparam logic [11:0] ADR_OPTION = 12'h000;
   localparam logic [11:0] ADR_STATUS = 12'h004;
   localparam logic [11:0] ADR_FLAGS = 12'h008;
   localparam logic [11:0] ADR_VECTOR = 12'h00C;
   localparam int FLG_WDG_BIT = 0;
   localparam int FLG_LOWV_BIT = 4;
   localparam int ST_PHASE_LSB = 0;
   localparam int ST_CFG_ERR = 2;
   localparam int ST_PLL_ON = 3;
   localparam int ST_RANGE_ERR = 4;
   localparam int ST_LOWV = 5;
   localparam int ST_PIN = 6;
   localparam int ST_CORE_RUN = 7;
   // ==========================================================
   // Types
   typedef enum logic [1:0] {SRC_EXT, SRC_RES, SRC_RC, SRC_BAD} rcs_src_e;
   typedef enum logic [1:0] {PH_ACTIVE, PH_DELAY, PH_FETCH, PH_RUN} rcs_phase_e;
   typedef struct packed {
      logic [4:0] per_cnt;
      logic [4:0] half;
      logic in_range;
      logic div_tog;
      logic cpu_en;
      logic pll_on;
      logic cfg_err;
      logic res_en;
      logic rc_en;
      logic [2:0] range_sel;
   } rcs_clk_s;
   typedef struct packed {
      rcs_phase_e phase;
      logic [7:0] opt;
      logic [7:0] act_opt;
      logic [2:0] in_cnt;
      logic [5:0] wdg_cnt;
      logic [12:0] dly_cnt;
      logic fetch_idx;
      logic [15:0] vec;
      logic vec_rd;
      logic [15:0] vec_addr;
      logic pin_oe;
      logic core_rst_n;
      logic core_en;
      logic lowv_flag;
      logic wdg_flag;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } rcs_seq_s;

   function automatic logic is_mapped(input logic [11:0] a);
      return (a == ADR_OPTION) || (a == ADR_STATUS) || (a == ADR_FLAGS) || (a == ADR_VECTOR);
   endfunction
endpackage

// >>> inc/rcs_clk_if.sv
/*
 Carrier between the sequencer and its clock selector.
 Assumes both ends run on pclk.
*/
`timescale 1ns/1ps
interface rcs_clk_if;
   rcs_pkg::rcs_src_e opt_src;
   logic [2:0] opt_range;
   logic opt_pll;
   logic tick_ext;
   logic tick_res;
   logic tick_rc;
   logic cpu_en;
   logic pll_on;
   logic cfg_err;
   logic range_err;
   logic res_en;
   logic rc_en;
   logic [2:0] range_sel;
   modport gen (input opt_src, opt_range, opt_pll, tick_ext, tick_res, tick_rc,
                output cpu_en, pll_on, cfg_err, range_err, res_en, rc_en, range_sel);
   modport seq (output opt_src, opt_range, opt_pll, tick_ext, tick_res, tick_rc,
                input cpu_en, pll_on, cfg_err, range_err, res_en, rc_en, range_sel);
endinterface // rcs_clk_if

// >>> rtl/rcs_clock_select.sv
/*
 Clock source selection, PLL doubler and divide-by-two, as CPU enables.
 Assumes oscillator ticks are one-cycle pulses synchronous to pclk.
*/
`timescale 1ns/1ps
module rcs_clock_select (
   input wire logic pclk,
   input wire logic presetn,
   rcs_clk_if.gen cif
);
   rcs_pkg::rcs_clk_s s, n;
   logic tick;
   logic pll_req;
   logic pll_req_q;

   // ==========================================================
   // Next state
   always_comb begin
      n = s;
      tick = 1'b0;
      unique case (cif.opt_src)
         rcs_pkg::SRC_EXT: tick = cif.tick_ext;
         rcs_pkg::SRC_RES: tick = cif.tick_res;
         rcs_pkg::SRC_RC: tick = cif.tick_rc;
         default: tick = cif.tick_ext;
      endcase
      // Doubler with the RC source is refused, clock falls back to divide-by-two
      n.cfg_err = (cif.opt_pll && cif.opt_src == rcs_pkg::SRC_RC) ||
                  cif.opt_src == rcs_pkg::SRC_BAD || cif.opt_range > rcs_pkg::RANGE_MAX;
      pll_req = cif.opt_pll && cif.opt_src != rcs_pkg::SRC_RC;
      // Resonators stay on through every reset phase
      n.res_en = cif.opt_src == rcs_pkg::SRC_RES;
      n.rc_en = cif.opt_src == rcs_pkg::SRC_RC;
      n.range_sel = (cif.opt_range > rcs_pkg::RANGE_MAX) ? rcs_pkg::RANGE_MAX : cif.opt_range;
      n.cpu_en = 1'b0;
      if (tick) begin
         n.per_cnt = 5'h01;
         n.half = {1'b0, s.per_cnt[4:1]};
         n.in_range = s.per_cnt >= rcs_pkg::PLL_PER_MIN && s.per_cnt <= rcs_pkg::PLL_PER_MAX;
         n.div_tog = ~s.div_tog;
         n.cpu_en = s.pll_on ? 1'b1 : s.div_tog;
      end else begin
         if (s.per_cnt != rcs_pkg::PER_SAT) begin
            n.per_cnt = s.per_cnt + 5'h01;
         end
         // Second pulse midway through the input period doubles the rate
         n.cpu_en = s.pll_on && s.per_cnt == s.half;
      end
      // Out-of-range input cannot be doubled, so the plain divider is used
      n.pll_on = pll_req && n.in_range;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign cif.cpu_en = s.cpu_en;
   assign cif.pll_on = s.pll_on;
   assign cif.cfg_err = s.cfg_err;
   assign cif.range_err = pll_req_q;
   assign cif.res_en = s.res_en;
   assign cif.rc_en = s.rc_en;
   assign cif.range_sel = s.range_sel;

   always_comb begin
      pll_req_q = cif.opt_pll && cif.opt_src != rcs_pkg::SRC_RC && !s.in_range;
   end
endmodule // rcs_clock_select

// >>> rtl/rcs_reset_sequencer.sv
/*
 Reset sequencer top: merges pin, low-voltage and watchdog reset sources,
 drives the open-drain reset pin, counts the stabilisation delay in CPU
 cycles, fetches the reset vector and releases the core. APB slave for
 option, status, cause flags and fetched vector.
 Assumes all inputs synchronous to pclk; the pin level is resolved outside.
*/
//
// Behaviour
// - With PLL, a 2 to 4 MHz input is doubled to give 4 to 8 MHz.
// - Option selects PLL; without it core clock is oscillator divided by two.
// - PLL together with RC oscillator is refused as a bad configuration.
// - Option picks external clock, one of five resonator ranges, or RC.
// - Resonator oscillators keep running during reset, no restart time.
// - All three sources act on the reset pin; held low during delay.
// - After the delay the handler address is read from the top two bytes.
// - Each reset runs active phase, then delay, then vector fetch.
// - Delay is 4096 CPU cycles when long; option picks the length.
// - Vector fetch lasts exactly two CPU clock cycles.
// - Reset pin is input and open-drain output, only ever driven low.
// - Outside holds pin low a minimum width; detection works in halt.
// - Pin driven low while the low-voltage source reports low supply.
// - Watchdog underflow drives pin low a minimum width, then sequence.
// - Delay lengths are 256 or 4096 CPU cycles.
`timescale 1ns/1ps
module rcs_reset_sequencer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rst_pin_in,
   output logic rst_pin_out,
   output logic rst_pin_oe,
   input wire logic low_voltage_reset_source,
   input wire logic wdg_underflow,
   input wire logic osc_ext_tick,
   input wire logic osc_res_tick,
   input wire logic osc_rc_tick,
   input wire logic core_halt,
   output logic res_osc_en,
   output logic rc_osc_en,
   output logic [2:0] res_osc_range,
   output logic derived_core_clock_en,
   output logic core_reset_n,
   output logic vec_rd,
   output logic [15:0] vec_addr,
   input wire logic [7:0] vec_data
);
   rcs_pkg::rcs_seq_s s, n;
   rcs_clk_if cif ();

   logic ext_low;
   logic ext_active;
   logic lowv_src;
   logic wdg_src;
   logic src_any;
   logic release_ok;
   logic dly_done;
   logic setup;
   logic wr;
   logic [31:0] rd_word;

   // ==========================================================
   // Clock selection
   assign cif.opt_src = rcs_pkg::rcs_src_e'(s.act_opt[rcs_pkg::OPT_SRC_LSB +: 2]);
   assign cif.opt_range = s.act_opt[rcs_pkg::OPT_RANGE_LSB +: 3];
   assign cif.opt_pll = s.act_opt[rcs_pkg::OPT_PLL_BIT];
   assign cif.tick_ext = osc_ext_tick;
   assign cif.tick_res = osc_res_tick;
   assign cif.tick_rc = osc_rc_tick;

   rcs_clock_select u_clk (
      .pclk(pclk),
      .presetn(presetn),
      .cif(cif)
   );

   // ==========================================================
   // Register read mux
   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (paddr)
         rcs_pkg::ADR_OPTION: begin
            rd_word[7:0] = s.opt;
         end
         rcs_pkg::ADR_STATUS: begin
            rd_word[rcs_pkg::ST_PHASE_LSB +: 2] = s.phase;
            rd_word[rcs_pkg::ST_CFG_ERR] = cif.cfg_err;
            rd_word[rcs_pkg::ST_PLL_ON] = cif.pll_on;
            rd_word[rcs_pkg::ST_RANGE_ERR] = cif.range_err;
            rd_word[rcs_pkg::ST_LOWV] = low_voltage_reset_source;
            rd_word[rcs_pkg::ST_PIN] = rst_pin_in;
            rd_word[rcs_pkg::ST_CORE_RUN] = s.core_rst_n;
         end
         rcs_pkg::ADR_FLAGS: begin
            rd_word[rcs_pkg::FLG_WDG_BIT] = s.wdg_flag;
            rd_word[rcs_pkg::FLG_LOWV_BIT] = s.lowv_flag;
         end
         rcs_pkg::ADR_VECTOR: begin
            rd_word[15:0] = s.vec;
         end
         default: begin
            rd_word = 32'h0000_0000;
         end
      endcase
   end

   // ==========================================================
   // Next state
   always_comb begin
      n = s;
      setup = psel && !penable;
      wr = psel && penable && pwrite && s.pready;

      // Own drive and the fetch window are masked, else the sequencer would re-trigger itself
      ext_low = !rst_pin_in && !s.pin_oe && s.phase != rcs_pkg::PH_FETCH;
      // Pin sampled on pclk, which runs in halt, so halt does not hide a pin reset
      if (!ext_low) begin
         n.in_cnt = 3'h0;
      end else if (s.in_cnt != rcs_pkg::IN_PULSE_CYC) begin
         n.in_cnt = s.in_cnt + 3'h1;
      end
      ext_active = ext_low && n.in_cnt == rcs_pkg::IN_PULSE_CYC;
      lowv_src = low_voltage_reset_source;
      wdg_src = wdg_underflow;
      src_any = ext_active || lowv_src || wdg_src;

      // ---------------------------------------------------------
      // Watchdog output pulse length
      if (wdg_src) begin
         n.wdg_cnt = rcs_pkg::OUT_PULSE_CYC;
      end else if (s.phase == rcs_pkg::PH_ACTIVE && s.wdg_cnt != 6'h00) begin
         n.wdg_cnt = s.wdg_cnt - 6'h01;
      end
      // While we drive the pin an outside hold cannot be seen
      release_ok = !lowv_src && n.wdg_cnt == 6'h00 && !ext_active && (s.pin_oe || rst_pin_in);
      dly_done = cif.cpu_en && s.dly_cnt == (s.act_opt[rcs_pkg::OPT_LONG_BIT] ?
                 rcs_pkg::DLY_LONG_LAST : rcs_pkg::DLY_SHORT_LAST);

      // ---------------------------------------------------------
      // Sequence
      if (src_any && s.phase != rcs_pkg::PH_ACTIVE) begin
         n.phase = rcs_pkg::PH_ACTIVE;
         n.act_opt = s.opt;
         n.core_rst_n = 1'b0;
         n.vec_rd = 1'b0;
         n.pin_oe = lowv_src || wdg_src;
      end else begin
         unique case (s.phase)
            rcs_pkg::PH_ACTIVE: begin
               n.core_rst_n = 1'b0;
               if (release_ok) begin
                  n.phase = rcs_pkg::PH_DELAY;
                  n.dly_cnt = 13'h0000;
                  n.pin_oe = 1'b1;
               end else begin
                  n.pin_oe = lowv_src || n.wdg_cnt != 6'h00;
               end
            end
            rcs_pkg::PH_DELAY: begin
               n.pin_oe = 1'b1;
               if (dly_done) begin
                  n.phase = rcs_pkg::PH_FETCH;
                  n.pin_oe = 1'b0;
                  n.vec_rd = 1'b1;
                  n.vec_addr = rcs_pkg::VEC_HI_ADDR;
                  n.fetch_idx = 1'b0;
               end else if (cif.cpu_en) begin
                  n.dly_cnt = s.dly_cnt + 13'h0001;
               end
            end
            rcs_pkg::PH_FETCH: begin
               // One byte per CPU cycle, high byte first
               if (cif.cpu_en) begin
                  if (!s.fetch_idx) begin
                     n.vec[15:8] = vec_data;
                     n.vec_addr = rcs_pkg::VEC_LO_ADDR;
                     n.fetch_idx = 1'b1;
                  end else begin
                     n.vec[7:0] = vec_data;
                     n.vec_rd = 1'b0;
                     n.phase = rcs_pkg::PH_RUN;
                     n.core_rst_n = 1'b1;
                  end
               end
            end
            rcs_pkg::PH_RUN: begin
               n.pin_oe = 1'b0;
            end
         endcase
      end

      // Core runs on CPU enables only out of reset and out of halt
      n.core_en = cif.cpu_en && n.core_rst_n && !core_halt;

      // ---------------------------------------------------------
      // Reset cause flags, write zero to clear, hardware set wins
      if (wr && paddr == rcs_pkg::ADR_FLAGS) begin
         n.lowv_flag = s.lowv_flag && pwdata[rcs_pkg::FLG_LOWV_BIT];
         n.wdg_flag = s.wdg_flag && pwdata[rcs_pkg::FLG_WDG_BIT];
      end
      if (lowv_src) begin
         n.lowv_flag = 1'b1;
         n.wdg_flag = 1'b0;
      end else if (wdg_src) begin
         n.wdg_flag = 1'b1;
      end

      // ---------------------------------------------------------
      // APB: no wait state, answer registered in the setup cycle
      n.pready = setup;
      n.pslverr = setup && !rcs_pkg::is_mapped(paddr);
      if (setup) begin
         n.prdata = pwrite ? 32'h0000_0000 : rd_word;
      end
      // Options take effect at the next reset sequence
      if (wr && paddr == rcs_pkg::ADR_OPTION) begin
         n.opt = pwdata[7:0] & rcs_pkg::OPT_MASK;
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.phase <= rcs_pkg::PH_ACTIVE;
         s.opt <= rcs_pkg::OPT_RESET;
         s.act_opt <= rcs_pkg::OPT_RESET;
         s.pin_oe <= 1'b1;
      end else begin
         s <= n;
      end
   end

   // ==========================================================
   // Outputs
   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign rst_pin_out = 1'b0;
   assign rst_pin_oe = s.pin_oe;
   assign res_osc_en = cif.res_en;
   assign rc_osc_en = cif.rc_en;
   assign res_osc_range = cif.range_sel;
   assign derived_core_clock_en = s.core_en;
   assign core_reset_n = s.core_rst_n;
   assign vec_rd = s.vec_rd;
   assign vec_addr = s.vec_addr;
endmodule // rcs_reset_sequencer

// >>> bench/rcs_seq_assertions.sv
/*
 Port checker of the reset sequencer.
 Assumes one pclk domain; attached by the bind at the foot of this file.
*/
`timescale 1ns/1ps
module rcs_seq_assertions (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic rst_pin_in,
   input wire logic rst_pin_out,
   input wire logic rst_pin_oe,
   input wire logic low_voltage_reset_source,
   input wire logic wdg_underflow,
   input wire logic core_reset_n,
   input wire logic vec_rd,
   input wire logic [15:0] vec_addr
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================================================
   // Reset sources and pin
   wdg_pulse_width_a: assert property (
      wdg_underflow |=> rst_pin_oe [*8] ##1 rst_pin_oe [*8] ##1 rst_pin_oe [*4])
      else $error("watchdog pin pulse too short");
   lowv_holds_pin_a: assert property (
      low_voltage_reset_source |=> rst_pin_oe && !core_reset_n)
      else $error("low supply not driving pin");
   pin_low_only_a: assert property (rst_pin_out == 1'b0)
      else $error("pin driven high");
   delay_holds_core_a: assert property (rst_pin_oe |-> !core_reset_n)
      else $error("core released while pin held");
   // Two samples low, then restart within a short bound
   pin_detect_a: assert property (
      (!rst_pin_in && !rst_pin_oe && !vec_rd) [*2] |-> ##[1:4] !core_reset_n)
      else $error("outside pin reset missed");
   // ==========================================================
   // Vector fetch
   fetch_entry_a: assert property (
      $rose(vec_rd) |-> $past(rst_pin_oe) && !rst_pin_oe && vec_addr == 16'hFFFE)
      else $error("fetch entry wrong");
   fetch_exit_a: assert property (
      $fell(vec_rd) && !$past(wdg_underflow) && !$past(low_voltage_reset_source)
      |-> core_reset_n && $past(vec_addr) == 16'hFFFF)
      else $error("fetch exit wrong");
   // ==========================================================
   // Register bus
   apb_answer_a: assert property (psel && !penable |=> pready)
      else $error("bus answer late");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
endmodule // rcs_seq_assertions

bind rcs_reset_sequencer rcs_seq_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr), .rst_pin_in(rst_pin_in),
   .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
   .low_voltage_reset_source(low_voltage_reset_source), .wdg_underflow(wdg_underflow),
   .core_reset_n(core_reset_n), .vec_rd(vec_rd), .vec_addr(vec_addr));

// >>> bench/rcs_board_reset.sv
/*
 Board side of the shared reset pin: outside reset circuit and pull-up.
 Assumes a high device enable means the device sinks the pin.
*/
`timescale 1ns/1ps
module rcs_board_reset (
   input wire logic ext_pull,
   input wire logic dev_oe,
   output logic pin
);
   // Weak pull-up wins only when nobody sinks the line
   assign pin = !(ext_pull || dev_oe);
endmodule // rcs_board_reset

// >>> bench/tb_top.sv
/*
 Self-checking bench of the reset sequencer: register rows, then watchdog,
 pin, low-voltage and clock option cases.
 Assumes the checker binds itself to the design.
*/
`timescale 1ns/1ps
module tb_top;
   typedef struct {
      logic w;
      logic [11:0] a;
      logic [31:0] d;
      logic [31:0] q;
      logic e;
   } rcs_row_s;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, tick, core_halt, ext_pull;
   logic rst_pin_in, rst_pin_out, rst_pin_oe, lowv, wdg, res_osc_en, rc_osc_en, cpu_en, core_reset_n, vec_rd;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] res_osc_range;
   logic [15:0] vec_addr;
   logic [7:0] vec_data;
   int miscompares, comparisons, cycles, tick_per, tcnt, oe_n, vr_n, res_n, n, per;
   rcs_row_s rows [7];
   logic [7:0] opts [10];

   rcs_reset_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
      .low_voltage_reset_source(lowv), .wdg_underflow(wdg), .osc_ext_tick(tick), .osc_res_tick(tick),
      .osc_rc_tick(tick), .core_halt(core_halt), .res_osc_en(res_osc_en), .rc_osc_en(rc_osc_en),
      .res_osc_range(res_osc_range), .derived_core_clock_en(cpu_en), .core_reset_n(core_reset_n),
      .vec_rd(vec_rd), .vec_addr(vec_addr), .vec_data(vec_data));
   rcs_board_reset board (.ext_pull(ext_pull), .dev_oe(rst_pin_oe), .pin(rst_pin_in));

   // Released bus shows a changing pattern, not the last byte
   assign vec_data = !vec_rd ? 8'(cycles) : (vec_addr == 16'hFFFE ? 8'hAB : 8'hCD);

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      cycles <= cycles + 1;
      tcnt <= (tcnt >= tick_per - 1) ? 0 : tcnt + 1;
      tick <= (tcnt >= tick_per - 1);
      if (cycles == 80000) begin
         miscompares++;
         close_out();
      end
   end

   // ==========================================================
   // Tasks
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // Only the bench timeout ends this wait
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Source 0 watchdog, 1 low supply, 2 outside pin
   task automatic run_reset(input int src);
      oe_n = 0;
      vr_n = 0;
      res_n = 0;
      wdg <= (src == 0);
      lowv <= (src == 1);
      ext_pull <= (src == 2);
      repeat (src == 1 ? 30 : (src == 2 ? 3 : 1)) @(posedge pclk);
      {wdg, lowv, ext_pull} <= 3'h0;
      @(posedge pclk);
      while (core_reset_n !== 1'b1) begin
         @(posedge pclk);
         oe_n += (rst_pin_oe === 1'b1);
         vr_n += (vec_rd === 1'b1);
         res_n += (rst_pin_oe === 1'b1 && res_osc_en === 1'b1);
      end
   endtask

   task automatic count_en(input int len);
      n = 0;
      repeat (len) begin
         @(posedge pclk);
         n += (cpu_en === 1'b1);
      end
   endtask

   task automatic close_out();
      $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ==========================================================
   // Sequence
   initial begin
      rows = '{'{1'b0, 12'h000, 32'h0, 32'h40, 1'b0}, '{1'b1, 12'h000, 32'hFF, 32'h0, 1'b0},
               '{1'b0, 12'h000, 32'h0, 32'h7F, 1'b0}, '{1'b0, 12'h010, 32'h0, 32'h0, 1'b1},
               '{1'b1, 12'h010, 32'h12, 32'h0, 1'b1}, '{1'b1, 12'h000, 32'h0, 32'h0, 1'b0},
               '{1'b0, 12'h000, 32'h0, 32'h0, 1'b0}};
      opts = '{8'h01, 8'h05, 8'h09, 8'h0D, 8'h11, 8'h1D, 8'h02, 8'h20, 8'h22, 8'h03};
      {psel, penable, pwrite, lowv, wdg, core_halt, ext_pull} = 7'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      presetn = 1'b0;
      tick_per = 4;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         chk("row_data", rows[i].w ? 32'h0 : rows[i].q, rows[i].w ? 32'h0 : rd);
         chk("row_err", {31'h0, rows[i].e}, {31'h0, err});
      end
      run_reset(0);
      chk("wdg_oe_len", 32'h1, 32'(oe_n >= 255 * 8 + 18 && oe_n <= 256 * 8 + 32));
      chk("fetch_len", 32'd16, 32'(vr_n));
      apb(1'b0, 12'h00C, 32'h0);
      chk("vector", 32'h0000ABCD, rd);
      apb(1'b0, 12'h008, 32'h0);
      chk("flags_wdg", 32'h1, rd);
      apb(1'b0, 12'h004, 32'h0);
      chk("status_run", 32'hC3, rd & 32'hEF);
      count_en(160);
      chk("div2_rate", 32'd20, 32'(n));
      core_halt <= 1'b1;
      repeat (2) @(posedge pclk);
      count_en(80);
      chk("halt_rate", 32'd0, 32'(n));
      core_halt <= 1'b0;
      apb(1'b1, 12'h008, 32'h0);
      apb(1'b0, 12'h008, 32'h0);
      chk("flags_clr", 32'h0, rd);
      // One-cycle glitch is shorter than the minimum input pulse
      ext_pull <= 1'b1;
      @(posedge pclk);
      ext_pull <= 1'b0;
      repeat (6) @(posedge pclk);
      chk("glitch_ignored", 32'h1, {31'h0, core_reset_n});
      run_reset(2);
      chk("pin_oe_len", 32'h1, 32'(oe_n >= 255 * 8 - 8 && oe_n <= 256 * 8 + 8));
      apb(1'b0, 12'h008, 32'h0);
      chk("flags_pin", 32'h0, rd);
      apb(1'b1, 12'h000, 32'h40);
      run_reset(1);
      chk("lowv_oe_len", 32'h1, 32'(oe_n >= 4095 * 8 - 8 && oe_n <= 4096 * 8 + 8));
      apb(1'b0, 12'h008, 32'h0);
      chk("flags_lowv", 32'h10, rd);
      foreach (opts[i]) begin
         tick_per = opts[i][5] ? 12 : 4;
         per = (opts[i][5] && opts[i][1:0] != 2'h2) ? 6 : tick_per * 2;
         apb(1'b1, 12'h000, {24'h0, opts[i]});
         run_reset(0);
         chk("opt_fetch_len", 32'(per * 2), 32'(vr_n));
         chk("res_in_reset", {31'h0, opts[i][1:0] == 2'h1}, 32'(res_n >= oe_n - 2));
         chk("res_en", {31'h0, opts[i][1:0] == 2'h1}, {31'h0, res_osc_en});
         chk("rc_en", {31'h0, opts[i][1:0] == 2'h2}, {31'h0, rc_osc_en});
         if (opts[i][1:0] == 2'h1) begin
            chk("range", {29'h0, opts[i][4:2] > 3'h4 ? 3'h4 : opts[i][4:2]}, {29'h0, res_osc_range});
         end
         apb(1'b0, 12'h004, 32'h0);
         // Bad source code and out-of-range resonator range are flagged like PLL with RC
         chk("pll_cfg", {30'h0, per == 6, opts[i] == 8'h22 || opts[i][1:0] == 2'h3 || opts[i][4:2] > 3'h4},
            (rd >> 2) & 32'h3);
         count_en(240);
         chk("cpu_rate", 32'(240 / per), 32'(n));
      end
      close_out();
   end
endmodule // tb_top
